//--- verilog/pdc_channel.sv
// How it works
// RQ1: each transfer moves one datum, bumps address, drops counter
// RQ2: register file mode: address at even register, counter at next odd
// RQ3: counter pointer bit 0 set picks register file, clear picks memory
// RQ4: memory mode uses 16-bit pairs for counter and address
// RQ5: address pointer bit 0 picks the segment register in memory mode
// RQ6: software keeps descriptors in 00h..DFh and preloads them
// RQ7: counter reaching zero raises end-of-block request
// RQ8: pending and mask make a request, run at instruction end if allowed
// RQ9: outside swap, zero count clears the mask; end-of-block if unmasked
// RQ10: no transfer acknowledged while top level service runs; code checks it only at sampling, not at acknowledge
// RQ11: requests are sampled once every 5 core clock cycles
// RQ12: a register file transfer takes 8 cycles
// RQ13: a memory transfer takes 16 cycles plus wait states
// RQ14: swap mode flips tables at block end, keeps mask, raises end-of-block
// RQ15: while swap stays enabled, tables keep alternating
// RQ16: software writes the counter pointer into bits 7:1
// RQ17: pending bit set by event, cleared by acknowledge, software may write
// RQ18: mask bits gate transfer requests and end-of-block interrupt
// RQ19: three-bit source priority, 0 highest, 7 lowest
// RQ20: software writes the address pointer into bits 7:1
// RQ21: direction comes from the peripheral, not from the channel
// RQ22: transfer beats an interrupt of the same priority
// RQ23: a transfer leaves the priority level alone and runs to its end
// RQ24: at most 222 bytes with register file, 65536 with memory
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pdc_defines.svh"
module pdc_channel
  import pdc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `PDC_SAMPLE_CYCLES,
  parameter int RF_CYCLES     = `PDC_RF_CYCLES,
  parameter int MEM_CYCLES    = `PDC_MEM_CYCLES
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        periph_trigger,
  input  wire logic        periph_to_store,
  input  wire logic [7:0]  periph_rdata,
  output logic             periph_rd,
  output logic             periph_wr,
  output logic      [7:0]  periph_wdata,
  input  wire logic [2:0]  current_priority_level,
  input  wire logic        top_isr_active,
  input  wire logic        other_irq_req,
  input  wire logic [2:0]  other_irq_prio,
  input  wire logic        instr_end,
  output logic             dma_request,
  output logic             dma_busy,
  output logic             block_end_irq,
  output logic             channel_irq_req,
  output logic      [7:0]  rf_addr,
  output logic             rf_rd,
  output logic             rf_wr,
  output logic      [7:0]  rf_wdata,
  input  wire logic [7:0]  rf_rdata,
  output logic             mem_req,
  output logic             mem_wr,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_wait,
  output logic             mem_seg_sel
);
  localparam logic [2:0] DIV_LAST = 3'(SAMPLE_CYCLES - 1);
  localparam logic [3:0] RF_LAST  = 4'(RF_CYCLES - 1);
  localparam logic [3:0] MEM_LAST = 4'(MEM_CYCLES - 1);
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic        take;
  logic [7:0]  cptr_reg, cptr_next;
  logic [7:0]  aptr_reg, aptr_next;
  logic [5:0]  ctrl_reg, ctrl_next;
  logic        swap_reg, swap_next;
  logic        tsel_reg, tsel_next;
  pdc_state_t  state_reg, state_next;
  logic [3:0]  step_reg, step_next;
  logic [2:0]  div_reg, div_next;
  logic [15:0] addr_reg, addr_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0]  data_reg, data_next;
  logic        eob_reg, eob_next;
  logic        rm, ip, dm, im;
  logic [2:0]  prl;
  logic        prio_ok, sample_en, stall, ack;
  logic [3:0]  last;
  logic [7:0]  cp, cp_odd, ap, ap_odd;
  logic [15:0] cnt_dec, addr_inc;
  // zero-wait slave: every transfer completes OKAY in one data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign take      = hsel & htrans[1] & hready;

  always_comb
  begin
    wr_pend_next = take & hwrite;
    wr_addr_next = take ? haddr[7:0] : wr_addr_reg;
    hrdata_next  = hrdata_reg;
    if (take & ~hwrite)
    begin
      unique case (haddr[7:0])
        `PDC_OFS_CPTR: hrdata_next = {24'h000000, cptr_reg};
        `PDC_OFS_APTR: hrdata_next = {24'h000000, aptr_reg};
        `PDC_OFS_CTRL: hrdata_next = {26'h0000000, ctrl_reg};
        `PDC_OFS_MODE: hrdata_next = {29'h00000000, dma_busy,
                                      tsel_reg, swap_reg};
        default:       hrdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg  <= hrdata_next;
    end
  end
  assign rm  = cptr_reg[`PDC_CPTR_RM]; // RQ3
  assign ip  = ctrl_reg[`PDC_CTRL_IP];
  assign dm  = ctrl_reg[`PDC_CTRL_DM];
  assign im  = ctrl_reg[`PDC_CTRL_IM];
  assign prl = ctrl_reg[2:0];
  // table 1 descriptors sit one pair above table 0
  assign cp     = {cptr_reg[7:1], 1'b0}
                  + (tsel_reg ? `PDC_SWAP_STEP : 8'h00); // RQ2 RQ16
  assign cp_odd = {cp[7:1], 1'b1};
  assign ap     = {aptr_reg[7:1], 1'b0}
                  + (tsel_reg ? `PDC_SWAP_STEP : 8'h00); // RQ4 RQ20
  assign ap_odd = {ap[7:1], 1'b1};
  assign cnt_dec  = cnt_reg - 16'h0001;
  assign addr_inc = addr_reg + 16'h0001;
  assign dma_request     = ip & dm; // RQ8 RQ18
  assign channel_irq_req = ip & im & ~dm; // RQ18
  assign dma_busy        = (state_reg == PDC_XFER); // RQ23
  assign block_end_irq   = eob_reg;
  assign periph_wdata    = data_reg;
  assign mem_addr        = addr_reg;
  assign mem_wdata       = data_reg;
  assign mem_seg_sel     = aptr_reg[`PDC_APTR_PS]; // RQ5
  assign sample_en       = (div_reg == DIV_LAST); // RQ11
  assign last            = rm ? RF_LAST : MEM_LAST; // RQ12 RQ13
  // lower value is higher priority; ties with an interrupt go to us
  assign prio_ok = (prl <= current_priority_level) // RQ8 RQ19
                   & ~top_isr_active // RQ10
                   & ~(other_irq_req & (other_irq_prio < prl)); // RQ22
  // the memory access step holds while the memory inserts waits
  assign stall = dma_busy & ~rm & (step_reg == 4'h5) & mem_wait; // RQ13
  always_comb
  begin
    cptr_next  = cptr_reg;
    aptr_next  = aptr_reg;
    ctrl_next  = ctrl_reg;
    swap_next  = swap_reg;
    tsel_next  = tsel_reg;
    state_next = state_reg;
    step_next  = step_reg;
    div_next   = sample_en ? 3'h0 : div_reg + 3'h1;
    addr_next  = addr_reg;
    cnt_next   = cnt_reg;
    data_next  = data_reg;
    eob_next   = 1'b0;
    ack        = 1'b0;
    rf_addr    = 8'h00;
    rf_rd      = 1'b0;
    rf_wr      = 1'b0;
    rf_wdata   = 8'h00;
    mem_req    = 1'b0;
    mem_wr     = 1'b0;
    periph_rd  = 1'b0;
    periph_wr  = 1'b0;

    if (wr_pend_reg)
    begin
      unique case (wr_addr_reg)
        `PDC_OFS_CPTR: cptr_next = hwdata[7:0];
        `PDC_OFS_APTR: aptr_next = hwdata[7:0];
        `PDC_OFS_CTRL: ctrl_next = hwdata[5:0]; // RQ17
        `PDC_OFS_MODE: swap_next = hwdata[`PDC_MODE_SWAP];
        default:       ;
      endcase
    end
    unique case (state_reg)
      PDC_IDLE:
      begin
        if (sample_en && dma_request && prio_ok) // RQ11
          state_next = PDC_PEND;
      end
      PDC_PEND:
      begin
        if (!dma_request)
          state_next = PDC_IDLE;
        else if (instr_end) // RQ8
        begin
          state_next = PDC_XFER;
          step_next  = 4'h0;
          ack        = 1'b1;
        end
      end
      PDC_XFER:
      begin
        // no abort path: once started the sequence always completes
        if (!stall)
          step_next = step_reg + 4'h1; // RQ23
        if (rm)
        begin
          unique case (step_reg)
            4'h0:
            begin
              rf_rd   = 1'b1;
              rf_addr = cp; // RQ2
            end
            4'h1:
            begin
              rf_rd     = 1'b1;
              rf_addr   = cp_odd; // RQ2
              addr_next = {8'h00, rf_rdata};
            end
            4'h2: cnt_next = {8'h00, rf_rdata}; // RQ24
            4'h3:
            begin
              rf_addr = addr_reg[7:0];
              if (periph_to_store) // RQ21
              begin
                rf_wr     = 1'b1;
                rf_wdata  = periph_rdata; // RQ1
                periph_rd = 1'b1;
              end
              else
                rf_rd = 1'b1;
            end
            4'h4:
              if (!periph_to_store)
                data_next = rf_rdata;
            4'h5:
            begin
              periph_wr = ~periph_to_store;
              rf_wr     = 1'b1;
              rf_addr   = cp;
              rf_wdata  = addr_inc[7:0]; // RQ1
            end
            4'h6:
            begin
              rf_wr    = 1'b1;
              rf_addr  = cp_odd;
              rf_wdata = cnt_dec[7:0]; // RQ1
            end
            default: ;
          endcase
        end
        else
        begin
          unique case (step_reg)
            4'h0:
            begin
              rf_rd   = 1'b1;
              rf_addr = cp; // RQ4
            end
            4'h1:
            begin
              rf_rd          = 1'b1;
              rf_addr        = cp_odd;
              cnt_next[15:8] = rf_rdata;
            end
            4'h2:
            begin
              rf_rd         = 1'b1;
              rf_addr       = ap; // RQ4
              cnt_next[7:0] = rf_rdata;
            end
            4'h3:
            begin
              rf_rd           = 1'b1;
              rf_addr         = ap_odd;
              addr_next[15:8] = rf_rdata;
            end
            4'h4:
            begin
              addr_next[7:0] = rf_rdata;
              if (periph_to_store) // RQ21
              begin
                data_next = periph_rdata;
                periph_rd = 1'b1;
              end
            end
            4'h5:
            begin
              mem_req = 1'b1; // RQ1
              mem_wr  = periph_to_store;
            end
            4'h6:
              if (!periph_to_store)
                data_next = mem_rdata;
            4'h7:
            begin
              periph_wr = ~periph_to_store;
              rf_wr     = 1'b1;
              rf_addr   = cp;
              rf_wdata  = cnt_dec[15:8]; // RQ1
            end
            4'h8:
            begin
              rf_wr    = 1'b1;
              rf_addr  = cp_odd;
              rf_wdata = cnt_dec[7:0];
            end
            4'h9:
            begin
              rf_wr    = 1'b1;
              rf_addr  = ap;
              rf_wdata = addr_inc[15:8]; // RQ1
            end
            4'ha:
            begin
              rf_wr    = 1'b1;
              rf_addr  = ap_odd;
              rf_wdata = addr_inc[7:0];
            end
            default: ;
          endcase
        end
        if (step_reg == last)
        begin
          state_next = PDC_IDLE;
          if (cnt_dec == 16'h0000) // RQ7
          begin
            eob_next = im; // RQ9 RQ14
            if (swap_reg)
              tsel_next = ~tsel_reg; // RQ14 RQ15
            else
              ctrl_next[`PDC_CTRL_DM] = 1'b0; // RQ9
          end
        end
      end
      default: state_next = PDC_IDLE;
    endcase
    // acknowledge clears pending, but a fresh event in that cycle wins
    if (ack)
      ctrl_next[`PDC_CTRL_IP] = 1'b0; // RQ17
    if (periph_trigger)
      ctrl_next[`PDC_CTRL_IP] = 1'b1; // RQ17
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cptr_reg  <= `PDC_RST_PTR;
      aptr_reg  <= `PDC_RST_PTR;
      ctrl_reg  <= `PDC_RST_CTRL;
      swap_reg  <= 1'b0;
      tsel_reg  <= 1'b0;
      state_reg <= PDC_IDLE;
      step_reg  <= 4'h0;
      div_reg   <= 3'h0;
      addr_reg  <= 16'h0000;
      cnt_reg   <= 16'h0000;
      data_reg  <= 8'h00;
      eob_reg   <= 1'b0;
    end
    else
    begin
      cptr_reg  <= cptr_next;
      aptr_reg  <= aptr_next;
      ctrl_reg  <= ctrl_next;
      swap_reg  <= swap_next;
      tsel_reg  <= tsel_next;
      state_reg <= state_next;
      step_reg  <= step_next;
      div_reg   <= div_next;
      addr_reg  <= addr_next;
      cnt_reg   <= cnt_next;
      data_reg  <= data_next;
      eob_reg   <= eob_next;
    end
  end

endmodule

//--- verilog/pdc_defines.svh
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH
// register byte offsets on the bus
`define PDC_OFS_CPTR 8'h00
`define PDC_OFS_CTRL 8'h04
`define PDC_OFS_APTR 8'h08
`define PDC_OFS_MODE 8'h0c
// field positions
`define PDC_CPTR_RM 0
`define PDC_APTR_PS 0
`define PDC_CTRL_IP 5
`define PDC_CTRL_DM 4
`define PDC_CTRL_IM 3
`define PDC_MODE_SWAP 0
`define PDC_MODE_TSEL 1
`define PDC_MODE_BUSY 2
// reset values
`define PDC_RST_PTR 8'h00
`define PDC_RST_CTRL 6'h00
// timing in core clock cycles
`define PDC_SAMPLE_CYCLES 5
`define PDC_RF_CYCLES 8
`define PDC_MEM_CYCLES 16
// distance between table 0 and table 1 descriptors
`define PDC_SWAP_STEP 8'h02
`endif

//--- verilog/pdc_pkg.sv
package pdc_pkg;
  typedef enum logic [1:0]
  {
    PDC_IDLE = 2'b00,
    PDC_PEND = 2'b01,
    PDC_XFER = 2'b10
  } pdc_state_t;
endpackage

//--- testbench/pdc_checker.sv
`timescale 1ns/1ps
module pdc_checker
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic dma_busy,
  input wire logic instr_end,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic mem_req,
  input wire logic mem_wait,
  input wire logic periph_rd,
  input wire logic periph_wr,
  input wire logic block_end_irq
);
  logic [5:0] len_reg;
  logic [5:0] len_next;
  logic [5:0] wait_reg;
  logic [5:0] wait_next;
  logic       mem_reg;
  logic       mem_next;
  // length and wait cycles of the transfer now running
  always_comb
  begin
    len_next  = dma_busy ? len_reg + 6'h01 : 6'h00;
    wait_next = dma_busy ? wait_reg + {5'h00, mem_req & mem_wait} : 6'h00;
    mem_next  = dma_busy & (mem_reg | mem_req);
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      len_reg  <= 6'h00;
      wait_reg <= 6'h00;
      mem_reg  <= 1'b0;
    end
    else
    begin
      len_reg  <= len_next;
      wait_reg <= wait_next;
      mem_reg  <= mem_next;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_rf_length: assert property ($fell(dma_busy) && !mem_reg |->
    len_reg == 6'h08) else $error("register file transfer length");
  a_mem_length: assert property ($fell(dma_busy) && mem_reg |->
    len_reg == 6'h10 + wait_reg) else $error("memory transfer length");
  a_mem_hold: assert property (mem_req && mem_wait |=> mem_req)
    else $error("memory request dropped while waiting");
  a_idle_quiet: assert property (!dma_busy |->
    !(rf_rd || rf_wr || mem_req || periph_rd || periph_wr))
    else $error("strobe outside a transfer");
  a_desc_first: assert property ($rose(dma_busy) |->
    rf_rd ##1 rf_rd) else $error("descriptor not read first");
  a_start_slot: assert property ($rose(dma_busy) |->
    $past(instr_end)) else $error("transfer began off instruction end");
  a_eob_after: assert property (block_end_irq |->
    !dma_busy && $past(dma_busy)) else $error("end of block misplaced");
  a_eob_single: assert property (block_end_irq |=>
    !block_end_irq) else $error("end of block longer than a cycle");
endmodule
bind pdc_channel pdc_checker chk
(
  .hclk, .hresetn, .dma_busy, .instr_end, .rf_rd, .rf_wr, .mem_req,
  .mem_wait, .periph_rd, .periph_wr, .block_end_irq
);

//--- testbench/pdc_partner.sv
`timescale 1ns/1ps
module pdc_partner
(
  input  wire logic        hclk,
  input  wire logic        slow,
  input  wire logic [7:0]  rf_addr,
  input  wire logic        rf_rd,
  input  wire logic        rf_wr,
  input  wire logic [7:0]  rf_wdata,
  output logic      [7:0]  rf_rdata,
  input  wire logic        mem_req,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_wait,
  input  wire logic        periph_rd,
  input  wire logic        periph_wr,
  input  wire logic [7:0]  periph_wdata,
  output logic      [7:0]  periph_rdata
);
  logic [7:0] rf [256];
  logic [7:0] mem [256];
  logic [7:0] pdat = 8'h5a;
  logic [7:0] pout;
  logic [1:0] wcnt = 2'h0;
  // a slow memory stretches every access by two cycles
  assign mem_wait = mem_req & slow & (wcnt != 2'h2);
  // idle lines show the inverse so stale data cannot pass for fresh
  assign periph_rdata = periph_rd ? pdat : ~pdat;
  always @(posedge hclk)
  begin
    wcnt <= mem_wait ? wcnt + 2'h1 : 2'h0;
    rf_rdata <= rf_rd ? rf[rf_addr] : ~rf_rdata;
    mem_rdata <= (mem_req & !mem_wait) ? mem[mem_addr[7:0]] : ~mem_rdata;
    if (rf_wr)
      rf[rf_addr] <= rf_wdata;
    if (mem_req & mem_wr & !mem_wait)
      mem[mem_addr[7:0]] <= mem_wdata;
    if (periph_rd)
      pdat <= pdat + 8'h01;
    if (periph_wr)
      pout <= periph_wdata;
  end
endmodule

//--- testbench/test_peripheral_dma_channel.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %0t %h vs %h", $time, a, e); end end
module test_peripheral_dma_channel;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic        dph = 1'b0, periph_trigger = 1'b0, periph_to_store = 1'b1;
  logic        top_isr_active = 1'b0, other_irq_req = 1'b0, slow = 1'b0;
  logic        instr_end = 1'b0;
  logic        hready, hreadyout, hresp, periph_rd, periph_wr, dma_busy;
  logic        block_end_irq, rf_rd, rf_wr, mem_req, mem_wr, mem_wait;
  logic        mem_seg_sel, dma_request, channel_irq_req;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2, current_priority_level = 3'h3;
  logic [2:0]  other_irq_prio = 3'h0;
  logic [7:0]  periph_rdata, periph_wdata, rf_addr, rf_wdata, rf_rdata;
  logic [7:0]  mem_wdata, mem_rdata, r1, r2;
  logic [15:0] mem_addr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, e;
  logic [31:0] seed = 32'h08f69d86;
  // rival request, rival level, go, top service, priority level, control
  logic [19:0] cs [5] = '{20'h0031d, 20'h00f18, 20'h1431b, 20'h1731b,
                          20'h0131b};
  logic [31:0] q [$];
  int          fail_count = 0, checked = 0, eob_cnt = 0, cyc = 0;
  assign hready = hreadyout;
  pdc_channel uut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .periph_trigger, .periph_to_store,
    .periph_rdata, .periph_rd, .periph_wr, .periph_wdata,
    .current_priority_level, .top_isr_active, .other_irq_req,
    .other_irq_prio, .instr_end, .dma_request, .dma_busy,
    .block_end_irq, .channel_irq_req, .rf_addr, .rf_rd, .rf_wr,
    .rf_wdata, .rf_rdata, .mem_req, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_wait, .mem_seg_sel
  );
  pdc_partner ptn
  (
    .hclk, .slow, .rf_addr, .rf_rd, .rf_wr, .rf_wdata, .rf_rdata, .mem_req,
    .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_wait, .periph_rd,
    .periph_wr, .periph_wdata, .periph_rdata
  );
  initial
    forever #20 hclk = ~hclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    dph    <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dph    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, logic [31:0] x);
    q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  // one trigger; the channel must start within the wait or never
  task automatic xfer(input logic go);
    int n;
    periph_trigger <= 1'b1;
    @(posedge hclk);
    periph_trigger <= 1'b0;
    n = 0;
    while (dma_busy !== 1'b1 && n < 40)
    begin
      @(negedge hclk);
      n++;
    end
    `CHK(dma_busy, go)
    while (dma_busy !== 1'b0)
      @(negedge hclk);
    // a served request drops pending; a refused one keeps asking
    `CHK(dma_request, !go)
    repeat (2) @(posedge hclk);
  endtask
  always @(posedge hclk)
  begin
    instr_end <= ^xs();
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      conclude();
    end
  end
  always @(negedge hclk)
  begin
    if (block_end_irq === 1'b1)
      eob_cnt++;
    if (dph)
    begin
      e = q.pop_front();
      `CHK(hrdata, e)
    end
  end
  initial
  begin
    ptn.rf[8'h20] = 8'h40;
    ptn.rf[8'h21] = 8'h02;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h10, 32'hff);
    for (int i = 0; i < 5; i++)
      rd(8'(4 * i), 32'h0);
    bus(1'b1, 8'h00, 32'h21);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, 8'h04, {24'h0, cs[i][7:0]});
      current_priority_level <= cs[i][10:8];
      top_isr_active <= cs[i][11];
      other_irq_req <= cs[i][16];
      other_irq_prio <= cs[i][15:13];
      xfer(cs[i][12]);
    end
    rd(8'h04, 32'h0b);
    bus(1'b1, 8'h04, 32'h2b);
    @(negedge hclk);
    `CHK(channel_irq_req, 1'b1)
    `CHK(dma_request, 1'b0)
    @(posedge hclk);
    `CHK(ptn.rf[8'h40], 8'h5a)
    `CHK(ptn.rf[8'h41], 8'h5b)
    `CHK(ptn.rf[8'h20], 8'h42)
    `CHK(ptn.rf[8'h21], 8'h00)
    `CHK(eob_cnt, 1)
    r1 = 8'(xs());
    r2 = 8'(xs());
    ptn.mem[8'h80] = r1;
    ptn.mem[8'h90] = r2;
    {ptn.rf[8'h30], ptn.rf[8'h31], ptn.rf[8'h32], ptn.rf[8'h33]} = 32'h10001;
    {ptn.rf[8'h34], ptn.rf[8'h35], ptn.rf[8'h36], ptn.rf[8'h37]} = 32'h800090;
    periph_to_store <= 1'b0;
    bus(1'b1, 8'h00, 32'h30);
    bus(1'b1, 8'h08, 32'h35);
    bus(1'b1, 8'h0c, 32'h01);
    bus(1'b1, 8'h04, 32'h1b);
    xfer(1'b1);
    `CHK(ptn.pout, r1)
    `CHK(mem_seg_sel, 1'b1)
    rd(8'h0c, 32'h03);
    rd(8'h04, 32'h1b);
    slow <= 1'b1;
    xfer(1'b1);
    `CHK(ptn.pout, r2)
    rd(8'h0c, 32'h01);
    `CHK(ptn.rf[8'h35], 8'h81)
    `CHK(ptn.rf[8'h37], 8'h91)
    `CHK(ptn.rf[8'h33], 8'h00)
    `CHK(eob_cnt, 3)
    // table 0 count is now zero, so this store wraps it instead of ending
    periph_to_store <= 1'b1;
    xfer(1'b1);
    `CHK(ptn.mem[8'h81], 8'h5c)
    `CHK(ptn.rf[8'h35], 8'h82)
    `CHK(ptn.rf[8'h31], 8'hff)
    `CHK(eob_cnt, 3)
    conclude();
  end
endmodule
